// [logic/chan_cmd_map.svh]
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 32-bit AHB-Lite word registers, 25 MHz mclk
// Notes: included by the top design file and the testbench
`ifndef CHAN_CMD_MAP_SVH
`define CHAN_CMD_MAP_SVH

`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_MASK_LO 8'h08
`define OFS_MASK_HI 8'h0C
`define OFS_AVAIL_LO 8'h10
`define OFS_AVAIL_HI 8'h14
`define OFS_MIN_COUNT 8'h18
`define OFS_ACTIVE_LO 8'h1C
`define OFS_ACTIVE_HI 8'h20
`define OFS_IRQ_STATUS 8'h24
`define OFS_IRQ_MASK 8'h28

// command bits of the control register
`define CMD_APPLY 0
`define CMD_SOFT_RESET 1
`define CMD_RESTORE 2
`define CMD_PERSIST 3

// status register fields
`define ST_PERSIST_BUSY 0
`define ST_RESET_PENDING 1
`define ST_BOOT_DONE 2
`define ST_REGION_LSB 4

// event bits, same layout in irq status and irq mask
`define EV_CMD_ACK 0
`define EV_MASK_REJECT 1
`define EV_PERSIST_DONE 2
`define EV_WIDTH 3

`define MASK_DEFAULT 64'hFFFF_FFFF_FFF7_FFFF
`define AVAIL_NORTH_AM 64'hFFFF_FFFF_FFFF_FFFF
`define AVAIL_OCEANIA 64'hFFFF_FFFE_0000_0000
`define AVAIL_SOUTH_AM 64'hFFFF_FFFE_0000_0FFF
`define AVAIL_SE_ASIA 64'h00FF_E000_0000_0000
`define MIN_COUNT_WIDE 7'h19
`define MIN_COUNT_NARROW 7'h0B

`define MCLK_KHZ 25000
`define SOFT_RESET_DELAY_MS 100
`define SOFT_RESET_DELAY_CYC (`SOFT_RESET_DELAY_MS * `MCLK_KHZ)
`define NV_WRITE_CYC 16

`endif

// [logic/chan_cmd_pkg.sv]
// Purpose: shared types of the channel command block
// Assumes: offsets and counts live in chan_cmd_map.svh
// Notes: boot states are Gray coded along the boot path
package chan_cmd_pkg;
  typedef enum logic [1:0] {
    REGION_NORTH_AM = 2'h0,
    REGION_OCEANIA = 2'h1,
    REGION_SOUTH_AM = 2'h2,
    REGION_SE_ASIA = 2'h3
  } region_type;

  typedef enum logic [1:0] {
    BOOT_REGION = 2'h0,
    BOOT_APPLY = 2'h1,
    BOOT_RUN = 2'h3
  } boot_type;
endpackage

// [logic/low_channel_pick.sv]
// Purpose: count the set bits of a channel set and keep the lowest few
// Assumes: purely combinational
// Notes: used for both the mask check and the active set selection
module low_channel_pick (
  input wire logic [63:0] cand,
  input wire logic [6:0] limit,
  output logic [6:0] total,
  output logic [63:0] picked
);
  always_comb begin
    total = 7'h00;
    picked = 64'h0;
    for (int i = 0; i < 64; i++) begin
      if (cand[i]) begin
        if (total < limit) begin
          picked[i] = 1'b1;
        end
        total = total + 7'h01;
      end
    end
  end
endmodule

// [logic/chan_cmd_top.sv]
// Purpose: special commands and channel mask handling behind AHB-Lite
// Assumes: one 25 MHz clock, region strap steady around reset release
// Notes: zero wait state slave, response always OKAY
`include "chan_cmd_map.svh"

module chan_cmd_top #(
  parameter int unsigned RESET_DELAY_CYC = `SOFT_RESET_DELAY_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire chan_cmd_pkg::region_type region_sel,
  output logic irq,
  output logic module_reset,
  output logic [63:0] active_channels
);
  import chan_cmd_pkg::*;

  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;

  logic [31:0] stage_lo_r, stage_lo_nxt;
  logic [63:0] mask_r, mask_nxt;
  logic [63:0] nv_mask_r, nv_mask_nxt;
  logic [63:0] nv_data_r, nv_data_nxt;
  logic [63:0] active_r, active_nxt;
  logic [63:0] avail_r, avail_nxt;
  logic [6:0] min_r, min_nxt;
  region_type region_r, region_nxt;
  boot_type boot_r, boot_nxt;
  logic [`EV_WIDTH-1:0] irq_stat_r, irq_stat_nxt;
  logic [`EV_WIDTH-1:0] irq_mask_r, irq_mask_nxt;
  logic irq_r, irq_nxt;
  logic rst_pend_r, rst_pend_nxt;
  logic [31:0] rst_cnt_r, rst_cnt_nxt;
  logic nv_busy_r, nv_busy_nxt;
  logic [4:0] nv_cnt_r, nv_cnt_nxt;
  logic mod_rst_r, mod_rst_nxt;

  logic addr_ok;
  logic ctrl_wr, mask_hi_wr;
  logic [63:0] cand_mask;
  logic [6:0] cand_total;
  logic [63:0] act_pick;
  logic [`EV_WIDTH-1:0] ev_set;

  assign addr_ok = hsel && htrans[1] && hready;
  assign ctrl_wr = wr_pend_r && (wr_addr_r == `OFS_CTRL) && !nv_busy_r;
  assign mask_hi_wr = wr_pend_r && (wr_addr_r == `OFS_MASK_HI);
  assign cand_mask = {hwdata, stage_lo_r} & avail_r;

  low_channel_pick u_cand (
    .cand(cand_mask),
    .limit(min_r),
    .total(cand_total),
    .picked()
  );

  // only the lowest minimum-count channels of mask and availability
  low_channel_pick u_active (
    .cand(mask_r & avail_r),
    .limit(min_r),
    .total(),
    .picked(act_pick)
  );

  always_comb begin
    wr_pend_nxt = addr_ok && hwrite;
    wr_addr_nxt = addr_ok ? haddr[7:0] : wr_addr_r;
    hrdata_nxt = 32'h0000_0000;
    if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        `OFS_STATUS: begin
          hrdata_nxt[`ST_PERSIST_BUSY] = nv_busy_r;
          hrdata_nxt[`ST_RESET_PENDING] = rst_pend_r;
          hrdata_nxt[`ST_BOOT_DONE] = (boot_r == BOOT_RUN);
          hrdata_nxt[`ST_REGION_LSB +: 2] = region_r;
        end
        `OFS_MASK_LO: hrdata_nxt = mask_r[31:0];
        `OFS_MASK_HI: hrdata_nxt = mask_r[63:32];
        `OFS_AVAIL_LO: hrdata_nxt = avail_r[31:0];
        `OFS_AVAIL_HI: hrdata_nxt = avail_r[63:32];
        `OFS_MIN_COUNT: hrdata_nxt = {25'h0, min_r};
        `OFS_ACTIVE_LO: hrdata_nxt = active_r[31:0];
        `OFS_ACTIVE_HI: hrdata_nxt = active_r[63:32];
        `OFS_IRQ_STATUS: hrdata_nxt = {29'h0, irq_stat_r};
        `OFS_IRQ_MASK: hrdata_nxt = {29'h0, irq_mask_r};
        default: hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  always_comb begin
    stage_lo_nxt = stage_lo_r;
    mask_nxt = mask_r;
    nv_mask_nxt = nv_mask_r;
    nv_data_nxt = nv_data_r;
    active_nxt = active_r;
    avail_nxt = avail_r;
    min_nxt = min_r;
    region_nxt = region_r;
    boot_nxt = boot_r;
    irq_mask_nxt = irq_mask_r;
    rst_pend_nxt = rst_pend_r;
    rst_cnt_nxt = rst_cnt_r;
    nv_busy_nxt = nv_busy_r;
    nv_cnt_nxt = nv_cnt_r;
    mod_rst_nxt = 1'b0;
    ev_set = '0;
    irq_stat_nxt = irq_stat_r;

    case (boot_r)
      BOOT_REGION: begin
        // strap taken after release, never under the async reset
        region_nxt = region_sel;
        boot_nxt = BOOT_APPLY;
        case (region_sel)
          REGION_OCEANIA: avail_nxt = `AVAIL_OCEANIA;
          REGION_SOUTH_AM: avail_nxt = `AVAIL_SOUTH_AM;
          REGION_SE_ASIA: avail_nxt = `AVAIL_SE_ASIA;
          default: avail_nxt = `AVAIL_NORTH_AM;
        endcase
        min_nxt = (region_sel == REGION_SE_ASIA) ? `MIN_COUNT_NARROW : `MIN_COUNT_WIDE;
      end
      BOOT_APPLY: begin
        active_nxt = act_pick;
        boot_nxt = BOOT_RUN;
      end
      BOOT_RUN: begin
        if (ctrl_wr && hwdata[`CMD_APPLY]) begin
          active_nxt = act_pick;
        end
      end
      default: boot_nxt = BOOT_REGION;
    endcase

    if (wr_pend_r && (wr_addr_r == `OFS_MASK_LO)) begin
      stage_lo_nxt = hwdata;
    end
    if (mask_hi_wr) begin
      if (cand_total < min_r) begin
        ev_set[`EV_MASK_REJECT] = 1'b1;
      end else begin
        mask_nxt = {hwdata, stage_lo_r};
      end
    end
    if (ctrl_wr && hwdata[`CMD_RESTORE]) begin
      mask_nxt = `MASK_DEFAULT;
      stage_lo_nxt = 32'(`MASK_DEFAULT);
    end
    if (ctrl_wr && hwdata[`CMD_PERSIST]) begin
      nv_busy_nxt = 1'b1;
      nv_cnt_nxt = 5'(`NV_WRITE_CYC);
      nv_data_nxt = mask_nxt;
    end else if (nv_busy_r) begin
      nv_cnt_nxt = nv_cnt_r - 5'h01;
      if (nv_cnt_r == 5'h01) begin
        nv_busy_nxt = 1'b0;
        nv_mask_nxt = nv_data_r;
        ev_set[`EV_PERSIST_DONE] = 1'b1;
      end
    end
    if (wr_pend_r && (wr_addr_r == `OFS_IRQ_MASK)) begin
      irq_mask_nxt = hwdata[`EV_WIDTH-1:0];
    end
    if (ctrl_wr && |hwdata[3:0]) begin
      ev_set[`EV_CMD_ACK] = 1'b1;
    end
    if (ctrl_wr && hwdata[`CMD_SOFT_RESET] && !rst_pend_r) begin
      rst_pend_nxt = 1'b1;
      rst_cnt_nxt = RESET_DELAY_CYC;
    end else if (rst_pend_r) begin
      rst_cnt_nxt = rst_cnt_r - 32'h1;
      if (rst_cnt_r == 32'h1) begin
        // full reset; the channel mask comes back from the persisted copy, irq mask clears
        rst_pend_nxt = 1'b0;
        mod_rst_nxt = 1'b1;
        mask_nxt = nv_mask_r;
        stage_lo_nxt = nv_mask_r[31:0];
        boot_nxt = BOOT_REGION;
        irq_mask_nxt = '0;
        nv_busy_nxt = 1'b0;
      end
    end

    // a new event wins over a clear in the same cycle
    if (wr_pend_r && (wr_addr_r == `OFS_IRQ_STATUS)) begin
      irq_stat_nxt = irq_stat_r & ~hwdata[`EV_WIDTH-1:0];
    end
    if (mod_rst_nxt) begin
      irq_stat_nxt = '0;
    end
    irq_stat_nxt = irq_stat_nxt | ev_set;
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage_lo_r <= 32'(`MASK_DEFAULT);
      mask_r <= `MASK_DEFAULT;
      nv_mask_r <= `MASK_DEFAULT;
      nv_data_r <= `MASK_DEFAULT;
      active_r <= 64'h0;
      avail_r <= 64'h0;
      min_r <= `MIN_COUNT_WIDE;
      region_r <= REGION_NORTH_AM;
      boot_r <= BOOT_REGION;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      irq_r <= 1'b0;
      rst_pend_r <= 1'b0;
      rst_cnt_r <= 32'h0;
      nv_busy_r <= 1'b0;
      nv_cnt_r <= 5'h00;
      mod_rst_r <= 1'b0;
    end else begin
      stage_lo_r <= stage_lo_nxt;
      mask_r <= mask_nxt;
      nv_mask_r <= nv_mask_nxt;
      nv_data_r <= nv_data_nxt;
      active_r <= active_nxt;
      avail_r <= avail_nxt;
      min_r <= min_nxt;
      region_r <= region_nxt;
      boot_r <= boot_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_r <= irq_nxt;
      rst_pend_r <= rst_pend_nxt;
      rst_cnt_r <= rst_cnt_nxt;
      nv_busy_r <= nv_busy_nxt;
      nv_cnt_r <= nv_cnt_nxt;
      mod_rst_r <= mod_rst_nxt;
    end
  end

  // zero wait state: hreadyout and hresp stay fixed after reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = hrdata_r;
  assign irq = irq_r;
  assign module_reset = mod_rst_r;
  assign active_channels = active_r;

  chk_apply_load: assert property (@(posedge mclk) disable iff (!rst_n)
    (ctrl_wr && hwdata[`CMD_APPLY] && boot_r == BOOT_RUN && !mod_rst_nxt)
      |=> active_r == $past(act_pick))
    else $error("apply did not load the active set");

  chk_reset_ack: assert property (@(posedge mclk) disable iff (!rst_n)
    (ctrl_wr && hwdata[`CMD_SOFT_RESET] && !rst_pend_r)
      |=> irq_stat_r[`EV_CMD_ACK] && rst_pend_r && !mod_rst_r)
    else $error("soft reset not acknowledged at once");

  chk_reset_late: assert property (@(posedge mclk) disable iff (!rst_n)
    module_reset |-> $past(rst_pend_r) && $past(rst_cnt_r) == 32'h1 && !rst_pend_r)
    else $error("module reset fired without its full delay");

  chk_restore_mask: assert property (@(posedge mclk) disable iff (!rst_n)
    (ctrl_wr && hwdata[`CMD_RESTORE] && !(rst_pend_r && rst_cnt_r == 32'h1))
      |=> mask_r == `MASK_DEFAULT)
    else $error("restore did not reload the default mask");

  chk_persist_store: assert property (@(posedge mclk) disable iff (!rst_n)
    (nv_busy_r && nv_cnt_r == 5'h01 && !ctrl_wr && !mod_rst_nxt)
      |=> nv_mask_r == $past(nv_data_r) && irq_stat_r[`EV_PERSIST_DONE])
    else $error("persist did not store the mask");

  chk_avail_fixed: assert property (@(posedge mclk) disable iff (!rst_n)
    (boot_r == BOOT_RUN && $past(boot_r) == BOOT_RUN) |-> $stable(avail_r))
    else $error("availability set changed while running");

  chk_active_allowed: assert property (@(posedge mclk) disable iff (!rst_n)
    boot_r == BOOT_RUN |-> (active_r & ~avail_r) == 64'h0)
    else $error("unavailable channel marked active");

  chk_reject_keep: assert property (@(posedge mclk) disable iff (!rst_n)
    (mask_hi_wr && cand_total < min_r && !mod_rst_nxt)
      |=> mask_r == $past(mask_r) && irq_stat_r[`EV_MASK_REJECT])
    else $error("rejected mask write changed the mask");

  chk_lowest_count: assert property (@(posedge mclk) disable iff (!rst_n)
    boot_r == BOOT_RUN |-> $countones(active_r) <= min_r)
    else $error("more channels active than the minimum count");

  chk_min_region: assert property (@(posedge mclk) disable iff (!rst_n)
    boot_r == BOOT_RUN |-> min_r == ((region_r == REGION_SE_ASIA) ?
      `MIN_COUNT_NARROW : `MIN_COUNT_WIDE))
    else $error("minimum count does not match the region");
endmodule

// [test/host_bus.sv]
// Purpose: host side bus master issuing single word transfers
// Assumes: AHB-Lite slave whose hreadyout is fed back as hready
// Notes: one transfer at a time; waits on hready with no fixed latency
module host_bus (
  input wire logic mclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hsel <= 1'b0;
    haddr <= 32'h0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    hwdata <= 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    // stale write data must not look valid outside the data phase
    hwdata <= ~hwdata;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask
endmodule

// [test/tb.sv]
// Purpose: self-checking bench of the channel command block
// Assumes: reset delay shortened to 20 cycles
// Notes: host model drives the bus; region strap driven here
`include "chan_cmd_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import chan_cmd_pkg::*;

  logic mclk, rst_n, hsel, hwrite, hreadyout, hresp, irq, module_reset;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [63:0] active_channels;
  region_type region_sel;
  int miscompares, n_checks, cyc;
  time t0;

  chan_cmd_top #(.RESET_DELAY_CYC(20)) uut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .region_sel(region_sel), .irq(irq), .module_reset(module_reset),
    .active_channels(active_channels));
  host_bus host (.mclk(mclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic expect_rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    host.rd(a, r);
    chk(r, exp);
  endtask

  task automatic boot(input region_type r);
    @(posedge mclk);
    rst_n <= 1'b0;
    region_sel <= r;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    q = 32'h0;
    while (q[`ST_BOOT_DONE] !== 1'b1) host.rd(`OFS_STATUS, q);
  endtask

  task automatic t_defaults();
    expect_rd(`OFS_MASK_LO, 32'hFFF7FFFF);
    expect_rd(`OFS_AVAIL_LO, 32'hFFFFFFFF);
    expect_rd(`OFS_AVAIL_HI, 32'hFFFFFFFF);
    expect_rd(`OFS_MIN_COUNT, 32'h19);
    expect_rd(`OFS_ACTIVE_LO, 32'h03F7FFFF);
    chk(active_channels[63:32], 32'h0);
    chk({31'h0, hresp}, 32'h0);
    host.wr(`OFS_AVAIL_LO, 32'h0);
    host.wr(`OFS_MIN_COUNT, 32'h0);
    expect_rd(`OFS_AVAIL_LO, 32'hFFFFFFFF);
    expect_rd(`OFS_MIN_COUNT, 32'h19);
  endtask

  task automatic t_reject();
    host.wr(`OFS_IRQ_MASK, 32'h2);
    host.wr(`OFS_MASK_LO, 32'h00FFFFFF);
    host.wr(`OFS_MASK_HI, 32'h0);
    expect_rd(`OFS_IRQ_STATUS, 32'h2);
    chk({31'h0, irq}, 32'h1);
    expect_rd(`OFS_MASK_LO, 32'hFFF7FFFF);
    host.wr(`OFS_IRQ_STATUS, 32'h2);
    expect_rd(`OFS_IRQ_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_apply();
    host.wr(`OFS_MASK_LO, 32'h0);
    host.wr(`OFS_MASK_HI, 32'hFFFFFFFF);
    expect_rd(`OFS_ACTIVE_LO, 32'h03F7FFFF);
    host.wr(`OFS_CTRL, 32'h1);
    expect_rd(`OFS_ACTIVE_LO, 32'h0);
    expect_rd(`OFS_ACTIVE_HI, 32'h01FFFFFF);
    // ack is masked, so the line must stay low
    expect_rd(`OFS_IRQ_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    host.wr(`OFS_MASK_LO, 32'h01FFFFFF);
    host.wr(`OFS_MASK_HI, 32'h0);
    expect_rd(`OFS_MASK_LO, 32'h01FFFFFF);
    expect_rd(`OFS_IRQ_STATUS, 32'h1);
    host.wr(`OFS_CTRL, 32'h4);
    expect_rd(`OFS_MASK_LO, 32'hFFF7FFFF);
    host.wr(`OFS_CTRL, 32'h1);
    expect_rd(`OFS_ACTIVE_LO, 32'h03F7FFFF);
  endtask

  task automatic t_persist_reset();
    host.wr(`OFS_MASK_LO, 32'h0FFFFFFF);
    host.wr(`OFS_MASK_HI, 32'hFFFFFFFF);
    host.wr(`OFS_CTRL, 32'h8);
    expect_rd(`OFS_STATUS, 32'h5);
    // host stays silent until the store completes
    repeat (17) @(posedge mclk);
    expect_rd(`OFS_IRQ_STATUS, 32'h5);
    host.wr(`OFS_CTRL, 32'h4);
    host.wr(`OFS_CTRL, 32'h2);
    t0 = $time;
    expect_rd(`OFS_IRQ_STATUS, 32'h5);
    do @(negedge mclk); while (module_reset !== 1'b1);
    chk(32'(($time - t0) / 40), 32'd20);
    q = 32'h0;
    while (q[`ST_BOOT_DONE] !== 1'b1) host.rd(`OFS_STATUS, q);
    expect_rd(`OFS_MASK_LO, 32'h0FFFFFFF);
    expect_rd(`OFS_ACTIVE_LO, 32'h01FFFFFF);
    expect_rd(`OFS_IRQ_STATUS, 32'h0);
  endtask

  task automatic t_narrow_region();
    boot(REGION_SE_ASIA);
    expect_rd(`OFS_MIN_COUNT, 32'h0B);
    expect_rd(`OFS_STATUS, 32'h34);
    expect_rd(`OFS_AVAIL_LO, 32'h0);
    expect_rd(`OFS_AVAIL_HI, 32'h00FFE000);
    expect_rd(`OFS_ACTIVE_HI, 32'h00FFE000);
    expect_rd(8'h80, 32'h0);
  endtask

  initial begin
    rst_n = 1'b0;
    region_sel = REGION_NORTH_AM;
    miscompares = 0;
    n_checks = 0;
    cyc = 0;
    boot(REGION_NORTH_AM);
    t_defaults();
    t_reject();
    t_apply();
    t_persist_reset();
    t_narrow_region();
    finish_test();
  end
endmodule
